// ### sdi_pkg.sv
package sdi_pkg;
  // microstep counter spans one electrical period (1024 microsteps)
  localparam int          CNT_W      = 10;
  localparam logic [9:0]  CNT_RST    = 10'h000;
  // resolution codes: 0 = 256 usteps ... 8 = fullstep
  localparam int          RES_W      = 4;
  localparam logic [3:0]  RES_MAX    = 4'h8;
  // sine amplitude width and table size (quarter wave)
  localparam int          AMP_W      = 9;
  localparam int          QTR_N      = 256;
  localparam logic [8:0]  AMP_RST    = 9'h000;
  // edge detector state reset
  localparam logic        STEP_RST   = 1'b0;

  // indexer phase, gray along idle -> move -> idle
  typedef enum logic [1:0] {
    SDI_IDLE = 2'b00,
    SDI_MOVE = 2'b01
  } sdi_state_t;
endpackage

// ### sdi_indexer.sv
// Functional notes
// [RL1] each axis selectable to external step/dir
// [RL2] external mode keeps internal ramp idle
// [RL3] rising only, or both edges when selected
// [RL4] direction sampled on each active edge
// [RL5] fullstep or 2..256 microsteps per fullstep
// [RL6] dir low counts up, high counts down
// [RL7] table turns counter into sine, cosine
// [RL8] counter wraps modulo one electrical period
`timescale 1ns/1ps
module sdi_indexer #(
  parameter int AXES = 2  // number of motor axes
) (
  input  wire logic              mclk_in,
  input  wire logic              nrst_in,
  input  wire logic [AXES-1:0]   ext_mode_in,        // axis on step/dir
  input  wire logic [AXES-1:0]   double_edge_select_in,
  input  wire logic [AXES*4-1:0] res_sel_in,         // per axis code
  input  wire logic [AXES-1:0]   step_in,            // pin, async
  input  wire logic [AXES-1:0]   dir_in,             // pin, async
  input  wire logic [AXES-1:0]   ramp_step_in,       // internal ramp
  input  wire logic [AXES-1:0]   ramp_dir_in,
  output logic      [AXES-1:0]   ramp_enable_out,    // ramp allowed
  output logic      [AXES*10-1:0] mscnt_out,         // ustep counter
  output logic      [AXES*9-1:0] sin_out,            // coil a target
  output logic      [AXES*9-1:0] cos_out,            // coil b target
  output logic      [AXES-1:0]   sin_neg_out,        // coil a sign
  output logic      [AXES-1:0]   cos_neg_out         // coil b sign
);

  // quarter sine lookup, magnitude rounded to nearest, peak 248
  function automatic logic [8:0] qsin(input logic [7:0] idx);
    real r;
    r = $sin(3.14159265358979 * (real'(idx) + 0.5) / 512.0) * 248.0;
    return 9'(int'(r));
  endfunction

  // signed position into magnitude and sign via quarter table
  function automatic logic [9:0] wave(input logic [9:0] ph);
    logic [7:0] i;
    i = ph[8] ? ~ph[7:0] : ph[7:0];
    return {ph[9], qsin(i)};
  endfunction

  // step size as power of two from resolution code
  // codes above fullstep clamp, so a bad code never jumps further
  function automatic logic [9:0] step_size(input logic [3:0] res);
    logic [3:0] r;
    r = (res > sdi_pkg::RES_MAX) ? sdi_pkg::RES_MAX : res;
    return 10'(10'h001 << r);
  endfunction

  // one independent indexer per axis; nothing is shared between axes
  genvar g;
  generate
    for (g = 0; g < AXES; g++) begin : g_axis
      logic       stp_m_q, stp_s_q, stp_p_q;  // step sync chain
      logic       dir_m_q, dir_s_q;           // dir sync chain
      logic       act;                        // active step edge
      logic       pulse, dir_sel;             // chosen source
      logic [9:0] cnt_q, cnt_d;               // microstep counter
      logic [9:0] ws, wc;                     // table outputs
      logic       en_q;                       // ramp enable reg
      logic [8:0] sin_q, cos_q;               // coil magnitudes
      logic       sin_neg_q, cos_neg_q;       // coil signs
      sdi_pkg::sdi_state_t st_q;              // last move marker

      // two-flop synchronisers for pin inputs
      always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          stp_m_q <= sdi_pkg::STEP_RST;
          stp_s_q <= sdi_pkg::STEP_RST;
          stp_p_q <= sdi_pkg::STEP_RST;
          dir_m_q <= 1'b0;
          dir_s_q <= 1'b0;
        end else begin
          stp_m_q <= step_in[g];
          stp_s_q <= stp_m_q;
          stp_p_q <= stp_s_q;
          dir_m_q <= dir_in[g];
          dir_s_q <= dir_m_q;
        end
      end

      // edge select: rising, or any when double edge set
      assign act = double_edge_select_in[g]               // [RL3]
                   ? (stp_s_q ^ stp_p_q)
                   : (stp_s_q & ~stp_p_q);

      // source mux: external pins or internal ramp
      always_comb begin
        if (ext_mode_in[g]) begin                         // [RL1]
          pulse   = act;
          dir_sel = dir_s_q;                              // [RL4]
        end else begin
          pulse   = ramp_step_in[g];
          dir_sel = ramp_dir_in[g];
        end
      end

      // counter step: low dir up, high dir down, wraps
      always_comb begin
        cnt_d = cnt_q;
        if (pulse) begin
          if (dir_sel)
            cnt_d = cnt_q - step_size(res_sel_in[g*4 +: 4]); // [RL6]
          else
            cnt_d = cnt_q + step_size(res_sel_in[g*4 +: 4]); // [RL5]
        end
      end

      // counter register, natural 10-bit wrap
      always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          cnt_q <= sdi_pkg::CNT_RST;
          st_q  <= sdi_pkg::SDI_IDLE;
        end else begin
          cnt_q <= cnt_d;                                 // [RL8]
          st_q  <= pulse ? sdi_pkg::SDI_MOVE : sdi_pkg::SDI_IDLE;
        end
      end

      // ramp held off while axis is externally driven
      always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in)
          en_q <= 1'b0;
        else
          en_q <= ~ext_mode_in[g];                        // [RL2]
      end

      // table lookup: cosine leads sine by a quarter period
      assign ws = wave(cnt_q);                            // [RL7]
      assign wc = wave(cnt_q + 10'(sdi_pkg::QTR_N));

      // registered coil targets
      always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          sin_q     <= sdi_pkg::AMP_RST;
          cos_q     <= sdi_pkg::AMP_RST;
          sin_neg_q <= 1'b0;
          cos_neg_q <= 1'b0;
        end else begin
          sin_q     <= ws[8:0];                           // [RL7]
          cos_q     <= wc[8:0];
          sin_neg_q <= ws[9];
          cos_neg_q <= wc[9];
        end
      end

      // per-axis slices of the flat output buses, all from flops
      assign mscnt_out[g*10 +: 10] = cnt_q;
      assign ramp_enable_out[g]    = en_q;
      assign sin_out[g*9 +: 9]     = sin_q;
      assign cos_out[g*9 +: 9]     = cos_q;
      assign sin_neg_out[g]        = sin_neg_q;
      assign cos_neg_out[g]        = cos_neg_q;

      // ramp idle in external mode
      a_ramp_off: assert property (                       // [RL2]
        @(posedge mclk_in) disable iff (!nrst_in)
        ext_mode_in[g] |=> !ramp_enable_out[g])
        else $error("ramp active in step/dir mode");
      // ramp pulses never move an externally driven counter
      a_ramp_ignored: assert property (                   // [RL2]
        @(posedge mclk_in) disable iff (!nrst_in)
        (ext_mode_in[g] && !act) |=> $stable(cnt_q))
        else $error("ramp step taken in step/dir mode");
      // an axis left on the ramp follows the ramp pulses
      a_ramp_path: assert property (                      // [RL1]
        @(posedge mclk_in) disable iff (!nrst_in)
        (!ext_mode_in[g] && ramp_step_in[g]) |=> !$stable(cnt_q))
        else $error("ramp step lost");
      // rising edge steps forward with dir low
      a_step_up: assert property (                        // [RL6]
        @(posedge mclk_in) disable iff (!nrst_in)
        (ext_mode_in[g] && act && !dir_s_q) |=>
        cnt_q == $past(cnt_q) + step_size($past(res_sel_in[g*4 +: 4])))
        else $error("forward step size wrong");
      // dir high steps back
      a_step_dn: assert property (                        // [RL4]
        @(posedge mclk_in) disable iff (!nrst_in)
        (ext_mode_in[g] && act && dir_s_q) |=>
        cnt_q == $past(cnt_q) - step_size($past(res_sel_in[g*4 +: 4])))
        else $error("reverse step wrong");
      // falling edge ignored without double edge
      a_fall_skip: assert property (                      // [RL3]
        @(posedge mclk_in) disable iff (!nrst_in)
        (ext_mode_in[g] && !double_edge_select_in[g] &&
         !stp_s_q && stp_p_q) |=> $stable(cnt_q))
        else $error("falling edge counted");
      // falling edge counted in double edge mode
      a_fall_take: assert property (                      // [RL3]
        @(posedge mclk_in) disable iff (!nrst_in)
        (ext_mode_in[g] && double_edge_select_in[g] &&
         !stp_s_q && stp_p_q) |=> !$stable(cnt_q))
        else $error("double edge missed");
      // pin edge reaches counter in three cycles
      a_pin_lat: assert property (                        // [RL1]
        @(posedge mclk_in) disable iff (!nrst_in)
        (ext_mode_in[g] && !step_in[g]) ##1
        (step_in[g] && ext_mode_in[g])[*3] |=> !$stable(cnt_q))
        else $error("step latency wrong");
      // wrap from top to zero
      a_wrap: assert property (                           // [RL8]
        @(posedge mclk_in) disable iff (!nrst_in)
        (cnt_q == 10'h3ff && pulse && !dir_sel &&
         res_sel_in[g*4 +: 4] == 4'h0) |=> cnt_q == 10'h000)
        else $error("counter did not wrap");
      // zero phase gives small sine, full cosine
      a_table: assert property (                          // [RL7]
        @(posedge mclk_in) disable iff (!nrst_in)
        cnt_q == 10'h000 |=> sin_out[g*9 +: 9] < cos_out[g*9 +: 9])
        else $error("table phase wrong");

      // main scenarios: pin step, double edge, reverse, wrap, move
      c_ext_step: cover property (@(posedge mclk_in) ext_mode_in[g] && act);
      c_dbl: cover property (@(posedge mclk_in)
        double_edge_select_in[g] && !stp_s_q && stp_p_q);
      c_rev: cover property (@(posedge mclk_in) act && dir_s_q);
      c_wrap: cover property (@(posedge mclk_in)
        cnt_q == 10'h3ff ##1 cnt_q == 10'h000);
      c_move: cover property (@(posedge mclk_in)
        st_q == sdi_pkg::SDI_MOVE ##1 st_q == sdi_pkg::SDI_IDLE);
    end
  endgenerate

endmodule // sdi_indexer

// ### sdi_step_src.sv
`timescale 1ns/1ps
// external step/dir source, one step and one dir line per axis
module sdi_step_src (
  input  wire logic       mclk_in,   // system clock for pacing
  output logic      [1:0] step_out,  // step pins
  output logic      [1:0] dir_out    // direction pins
);
  // pins rest low until the first move
  initial begin
    step_out = 2'h0;
    dir_out  = 2'h0;
  end
  // dir settles two cycles before the edge, step holds three cycles
  task automatic edge_to(input int ax, input logic d, input logic lvl);
    @(posedge mclk_in);
    #2 dir_out[ax] = d;
    repeat (2) @(posedge mclk_in);
    #2 step_out[ax] = lvl;
    repeat (3) @(posedge mclk_in);
  endtask
endmodule // sdi_step_src

// ### step_dir_microstep_indexer_tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  checked++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
module step_dir_microstep_indexer_tb_top;
  logic        mclk_in  = 1'b0;   // 50 mhz clock
  logic        nrst_in  = 1'b0;   // reset, active low
  logic [1:0]  ext_mode = 2'h0;   // axes on step/dir pins
  logic [1:0]  dbl_edge = 2'h0;   // both step edges active
  logic [1:0]  ramp_stp = 2'h0;   // internal ramp step pulses
  logic [7:0]  res_sel  = 8'h00;  // resolution codes
  logic [1:0]  step;              // from source model
  logic [1:0]  dir;               // from source model
  logic [1:0]  ramp_en;
  logic [19:0] mscnt;
  logic [17:0] sin_v;
  logic [17:0] cos_v;
  logic [1:0]  sin_n;
  logic [1:0]  cos_n;
  logic [9:0]  exp_cnt;           // expected axis 0 counter
  int          error_cnt = 0;
  int          checked   = 0;
  always #10 mclk_in = ~mclk_in;
  sdi_step_src i_sdi_step_src (.mclk_in(mclk_in), .step_out(step),
                               .dir_out(dir));
  sdi_indexer #(.AXES(2)) i_sdi_indexer (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .ext_mode_in(ext_mode),
    .double_edge_select_in(dbl_edge), .res_sel_in(res_sel),
    .step_in(step), .dir_in(dir), .ramp_step_in(ramp_stp),
    .ramp_dir_in(2'h0), .ramp_enable_out(ramp_en), .mscnt_out(mscnt),
    .sin_out(sin_v), .cos_out(cos_v), .sin_neg_out(sin_n),
    .cos_neg_out(cos_n));
  // one axis 0 edge, then wait for counter and table
  task automatic hit(input logic d, input logic lvl);
    i_sdi_step_src.edge_to(0, d, lvl);
    repeat (2) @(posedge mclk_in);
    #2;
  endtask
  // pins ignored in ramp mode, ramp held off in step/dir mode
  task automatic t_mode;
    hit(1'b0, 1'b1);
    hit(1'b0, 1'b0);
    `CHK(ramp_en, 2'h3)
    `CHK(mscnt[9:0], 10'h000)
    ext_mode = 2'h1;
    ramp_stp = 2'h3;
    @(posedge mclk_in);
    #2 ramp_stp = 2'h0;
    repeat (2) @(posedge mclk_in);
    #2;
    `CHK(ramp_en, 2'h2)
    `CHK(mscnt[9:0], 10'h000)
    `CHK(mscnt[19:10], 10'h001)
    `CHK(sin_v[8:0], 9'h001)
    `CHK(cos_v[8:0], 9'h0f8)
    `CHK(cos_n[0], 1'b0)
    $display("test mode done");
  endtask
  // resolution codes 0 to 8, falling edges ignored
  task automatic t_res;
    for (int c = 0; c < 9; c++) begin
      res_sel[3:0] = c[3:0];
      hit(1'b0, 1'b1);
      exp_cnt = exp_cnt + (10'h001 << c);
      `CHK(mscnt[9:0], exp_cnt)
      hit(1'b0, 1'b0);
      `CHK(mscnt[9:0], exp_cnt)
    end
    $display("test resolution done");
  endtask
  // counting down through zero wraps to the top
  task automatic t_wrap;
    hit(1'b1, 1'b1);
    hit(1'b1, 1'b0);
    hit(1'b1, 1'b1);
    `CHK(mscnt[9:0], 10'h3ff)
    res_sel[3:0] = 4'h0;
    hit(1'b0, 1'b0);
    hit(1'b0, 1'b1);
    `CHK(mscnt[9:0], 10'h000)
    $display("test wrap done");
  endtask
  // both edges count when selected
  task automatic t_dbl_edge;
    dbl_edge = 2'h1;
    res_sel[3:0] = 4'h8;
    hit(1'b1, 1'b0);
    `CHK(mscnt[9:0], 10'h300)
    `CHK(sin_v[8:0], 9'h0f8)
    `CHK(sin_n, 2'h1)
    `CHK(cos_v[8:0], 9'h001)
    hit(1'b0, 1'b1);
    `CHK(mscnt[9:0], 10'h000)
    `CHK(mscnt[19:10], 10'h001)
    $display("test double edge done");
  endtask
  // counts, verdict and end of run
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // reset for two cycles, then the scenarios
  initial begin
    exp_cnt = 10'h000;
    repeat (2) @(posedge mclk_in);
    #2 nrst_in = 1'b1;
    t_mode;
    t_res;
    t_wrap;
    t_dbl_edge;
    give_verdict;
  end
endmodule // step_dir_microstep_indexer_tb_top
